// >>> logic/aad_datapath.sv
`timescale 1ns/1ps
`default_nettype none
module aad_datapath #(
    parameter int FILE_DEPTH = aad_pkg::FILE_DEPTH
) (
    // Clock, reset and enable
    input  wire logic                        clock_in,
    input  wire logic                        rstn_in,
    input  wire logic                        clk_en_in,
    // Master clear pin, active low, not synchronous to clock_in
    input  wire logic                        master_clear_n_in,
    // Program bus
    input  wire logic [aad_pkg::INSTR_W-1:0] prog_word_in,
    output logic      [aad_pkg::PC_W-1:0]    prog_addr_out,
    // Observed core state
    output logic      [7:0]                  accum_out,
    output logic      [7:0]                  status_out,
    output var aad_pkg::aad_phase_t          phase_out,
    output logic                             cycle_out,
    // Data bus write observation
    output logic                             wr_strobe_out,
    output logic      [6:0]                  wr_addr_out,
    output logic      [7:0]                  wr_data_out
);
    // ------------------------------------------------------------
    // Decode and arithmetic functions
    // ------------------------------------------------------------

    // Split an instruction word into its control fields
    function automatic aad_pkg::aad_decode_t decode_word(input logic [13:0] ins);
        aad_pkg::aad_decode_t d;
        d         = '0;
        d.op      = aad_pkg::aad_op_t'(ins[aad_pkg::OP_HI:aad_pkg::OP_LO]);
        d.faddr   = ins[6:0];
        d.literal = ins[7:0];
        d.target  = ins[10:0];
        case (ins[aad_pkg::CLASS_HI:aad_pkg::CLASS_LO])
            aad_pkg::CLS_FILE: begin
                d.uses_file = 1'b1;
                if (d.op == aad_pkg::OP_RSVD) begin
                    d.op = aad_pkg::OP_NOP;
                end
                d.dest_file = (d.op == aad_pkg::OP_MOVWF) ||
                              (ins[aad_pkg::DEST_BIT] && d.op != aad_pkg::OP_NOP);
                d.dest_w    = !ins[aad_pkg::DEST_BIT] &&
                              d.op != aad_pkg::OP_NOP && d.op != aad_pkg::OP_MOVWF;
            end
            aad_pkg::CLS_LIT: begin
                if (d.op == aad_pkg::OP_MOVWF || d.op == aad_pkg::OP_RSVD) begin
                    d.op = aad_pkg::OP_NOP;
                end
                // Single-operand forms here act on the accumulator
                d.operand_w = !(d.op == aad_pkg::OP_ADD || d.op == aad_pkg::OP_SUB ||
                                d.op == aad_pkg::OP_AND || d.op == aad_pkg::OP_IOR ||
                                d.op == aad_pkg::OP_XOR || d.op == aad_pkg::OP_MOV);
                d.dest_w    = (d.op != aad_pkg::OP_NOP);
            end
            aad_pkg::CLS_BRANCH: begin
                d.op        = aad_pkg::OP_NOP;
                d.is_branch = 1'b1;
            end
            default: begin
                d.op = aad_pkg::OP_NOP;
            end
        endcase
        // Flags touched per opcode, order {zero, nibble, carry}
        case (d.op)
            aad_pkg::OP_ADD, aad_pkg::OP_SUB: d.flag_mask = 3'h7;
            aad_pkg::OP_RRF, aad_pkg::OP_RLF: d.flag_mask = 3'h1;
            aad_pkg::OP_NOP, aad_pkg::OP_MOVWF,
            aad_pkg::OP_SWAP:                 d.flag_mask = 3'h0;
            default:                          d.flag_mask = 3'h4;
        endcase
        return d;
    endfunction : decode_word

    // Eight-bit arithmetic and logic; second operand minus accumulator
    function automatic aad_pkg::aad_alu_t alu_calc(input aad_pkg::aad_op_t op,
                                                   input logic [7:0] w,
                                                   input logic [7:0] b,
                                                   input logic cin);
        aad_pkg::aad_alu_t r;
        logic [8:0] sum;
        logic [4:0] nib;
        r   = '0;
        sum = '0;
        nib = '0;
        case (op)
            aad_pkg::OP_ADD: begin
                sum = {1'b0, b} + {1'b0, w};
                nib = {1'b0, b[3:0]} + {1'b0, w[3:0]};
            end
            aad_pkg::OP_SUB: begin
                sum = {1'b0, b} + {1'b0, ~w} + 9'h001;
                nib = {1'b0, b[3:0]} + {1'b0, ~w[3:0]} + 5'h01;
            end
            default: begin
                sum = '0;
            end
        endcase
        case (op)
            aad_pkg::OP_ADD,
            aad_pkg::OP_SUB:   r.result = sum[7:0];
            aad_pkg::OP_AND:   r.result = b & w;
            aad_pkg::OP_IOR:   r.result = b | w;
            aad_pkg::OP_XOR:   r.result = b ^ w;
            aad_pkg::OP_COM:   r.result = ~b;
            aad_pkg::OP_INC:   r.result = b + 8'h01;
            aad_pkg::OP_DEC:   r.result = b - 8'h01;
            aad_pkg::OP_RRF:   r.result = {cin, b[7:1]};
            aad_pkg::OP_RLF:   r.result = {b[6:0], cin};
            aad_pkg::OP_SWAP:  r.result = {b[3:0], b[7:4]};
            aad_pkg::OP_MOVWF: r.result = w;
            aad_pkg::OP_CLR:   r.result = 8'h00;
            default:           r.result = b;
        endcase
        // Carry set means no borrow on subtract
        case (op)
            aad_pkg::OP_RRF: r.carry = b[0];
            aad_pkg::OP_RLF: r.carry = b[7];
            default:         r.carry = sum[8];
        endcase
        r.nibble_borrow_flag = nib[4];
        r.zero               = (r.result == 8'h00);
        return r;
    endfunction : alu_calc

    // Indirect slot follows the pointer register
    function automatic logic [6:0] resolve_addr(input logic [6:0] a, input logic [7:0] ptr);
        return (a == aad_pkg::ADDR_INDIRECT) ? ptr[6:0] : a;
    endfunction : resolve_addr

    // Addresses served by core registers rather than the array
    function automatic logic is_special(input logic [6:0] a);
        return (a == aad_pkg::ADDR_INDIRECT) || (a == aad_pkg::ADDR_PC_LOW) ||
               (a == aad_pkg::ADDR_STATUS)   || (a == aad_pkg::ADDR_POINTER);
    endfunction : is_special

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic                 mc_meta_reg;
    logic                 mc_sync_reg;
    logic                 core_run;
    aad_pkg::aad_phase_t  phase;
    aad_pkg::aad_decode_t dec;
    aad_pkg::aad_alu_t    alu_now;
    logic [6:0]           file_addr;
    logic [7:0]           operand_b;
    logic [7:0]           mem_rd_data;
    logic                 mem_rd_en;
    logic                 mem_wr_en;
    logic [7:0]           status_work;

    logic [13:0]          ir_reg,         ir_next;
    logic [12:0]          pc_reg,         pc_next;
    logic [12:0]          fetch_addr_reg, fetch_addr_next;
    logic [7:0]           w_reg,          w_next;
    logic [7:0]           status_reg,     status_next;
    logic [7:0]           ptr_reg,        ptr_next;
    logic [7:0]           operand_reg,    operand_next;
    aad_pkg::aad_alu_t    alu_reg,        alu_next;
    logic                 cycle_reg,      cycle_next;
    logic                 wr_strobe_reg,  wr_strobe_next;
    logic [6:0]           wr_addr_reg,    wr_addr_next;
    logic [7:0]           wr_data_reg,    wr_data_next;

    // ------------------------------------------------------------
    // Master clear synchroniser
    // ------------------------------------------------------------

    // Two flops before the pin is used
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            mc_meta_reg <= 1'b0;
            mc_sync_reg <= 1'b0;
        end else if (clk_en_in) begin
            mc_meta_reg <= master_clear_n_in;
            mc_sync_reg <= mc_meta_reg;
        end
    end

    // Core held while pin is low
    assign core_run = rstn_in && mc_sync_reg;

    // ------------------------------------------------------------
    // Phase generator and file memory
    // ------------------------------------------------------------
    aad_phase_gen u_phase (
        .clock_in  (clock_in),
        .rstn_in   (core_run),
        .clk_en_in (clk_en_in),
        .phase_out (phase)
    );

    aad_file_mem #(
        .ADDR_W (aad_pkg::FILE_AW),
        .DATA_W (aad_pkg::DATA_W),
        .DEPTH  (FILE_DEPTH)
    ) u_mem (
        .clock_in    (clock_in),
        .rstn_in     (core_run),
        .clk_en_in   (clk_en_in),
        .rd_en_in    (mem_rd_en),
        .rd_addr_in  (file_addr),
        .rd_data_out (mem_rd_data),
        .wr_en_in    (mem_wr_en),
        .wr_addr_in  (file_addr),
        .wr_data_in  (alu_reg.result)
    );

    // ------------------------------------------------------------
    // Operand selection
    // ------------------------------------------------------------

    // Decode, address and arithmetic of the executing word
    assign dec       = decode_word(ir_reg);
    assign file_addr = resolve_addr(dec.faddr, ptr_reg);
    assign operand_b = dec.uses_file ? operand_reg :
                       (dec.operand_w ? w_reg : dec.literal);
    assign alu_now   = alu_calc(dec.op, w_reg, operand_b, status_reg[aad_pkg::STAT_C]);
    assign mem_rd_en = (phase == aad_pkg::PH_DECODE);
    assign mem_wr_en = (phase == aad_pkg::PH_RESULT_WRITE) && dec.dest_file &&
                       !is_special(file_addr);

    // ------------------------------------------------------------
    // Core next state
    // ------------------------------------------------------------

    // Phase-ordered fetch, read, execute and write
    always_comb begin
        ir_next         = ir_reg;
        pc_next         = pc_reg;
        fetch_addr_next = fetch_addr_reg;
        w_next          = w_reg;
        status_next     = status_reg;
        ptr_next        = ptr_reg;
        operand_next    = operand_reg;
        alu_next        = alu_reg;
        cycle_next      = cycle_reg;
        wr_strobe_next  = 1'b0;
        wr_addr_next    = wr_addr_reg;
        wr_data_next    = wr_data_reg;
        status_work     = status_reg;
        case (phase)
            aad_pkg::PH_DECODE: begin
                fetch_addr_next = pc_reg;
                pc_next         = pc_reg + aad_pkg::PC_STEP;
                cycle_next      = 1'b0;
            end
            aad_pkg::PH_OPERAND_READ: begin
                case (file_addr)
                    aad_pkg::ADDR_PC_LOW:  operand_next = pc_reg[7:0];
                    aad_pkg::ADDR_STATUS:  operand_next = status_reg;
                    aad_pkg::ADDR_POINTER: operand_next = ptr_reg;
                    aad_pkg::ADDR_INDIRECT: operand_next = 8'h00;
                    default:               operand_next = mem_rd_data;
                endcase
            end
            aad_pkg::PH_EXECUTE: begin
                alu_next = alu_now;
            end
            aad_pkg::PH_RESULT_WRITE: begin
                cycle_next = 1'b1;
                ir_next    = prog_word_in;
                if (dec.dest_w) begin
                    w_next = alu_reg.result;
                end
                if (dec.dest_file) begin
                    wr_strobe_next = 1'b1;
                    wr_addr_next   = file_addr;
                    wr_data_next   = alu_reg.result;
                    case (file_addr)
                        aad_pkg::ADDR_STATUS:  status_work = alu_reg.result;
                        aad_pkg::ADDR_POINTER: ptr_next    = alu_reg.result;
                        aad_pkg::ADDR_PC_LOW: begin
                            pc_next = {pc_reg[12:8], alu_reg.result};
                            ir_next = aad_pkg::INSTR_NOP;
                        end
                        default: begin
                            ptr_next = ptr_reg;
                        end
                    endcase
                end
                if (dec.flag_mask[0]) begin
                    status_work[aad_pkg::STAT_C] = alu_reg.carry;
                end
                if (dec.flag_mask[1]) begin
                    status_work[aad_pkg::STAT_DC] = alu_reg.nibble_borrow_flag;
                end
                if (dec.flag_mask[2]) begin
                    status_work[aad_pkg::STAT_Z] = alu_reg.zero;
                end
                status_next = status_work;
                if (dec.is_branch) begin
                    pc_next = {pc_reg[12:11], dec.target};
                    ir_next = aad_pkg::INSTR_NOP;
                end
            end
            default: begin
                cycle_next = cycle_reg;
            end
        endcase
    end

    // Core registers, held in reset by either reset source
    always_ff @(posedge clock_in) begin
        if (!core_run) begin
            ir_reg         <= aad_pkg::INSTR_NOP;
            pc_reg         <= aad_pkg::PC_RST;
            fetch_addr_reg <= aad_pkg::PC_RST;
            w_reg          <= aad_pkg::W_RST;
            status_reg     <= aad_pkg::STATUS_RST;
            ptr_reg        <= aad_pkg::PTR_RST;
            operand_reg    <= 8'h00;
            alu_reg        <= '0;
            cycle_reg      <= 1'b0;
            wr_strobe_reg  <= 1'b0;
            wr_addr_reg    <= 7'h00;
            wr_data_reg    <= 8'h00;
        end else if (clk_en_in) begin
            ir_reg         <= ir_next;
            pc_reg         <= pc_next;
            fetch_addr_reg <= fetch_addr_next;
            w_reg          <= w_next;
            status_reg     <= status_next;
            ptr_reg        <= ptr_next;
            operand_reg    <= operand_next;
            alu_reg        <= alu_next;
            cycle_reg      <= cycle_next;
            wr_strobe_reg  <= wr_strobe_next;
            wr_addr_reg    <= wr_addr_next;
            wr_data_reg    <= wr_data_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign prog_addr_out = fetch_addr_reg;
    assign accum_out     = w_reg;
    assign status_out    = status_reg;
    assign phase_out     = phase;
    assign cycle_out     = cycle_reg;
    assign wr_strobe_out = wr_strobe_reg;
    assign wr_addr_out   = wr_addr_reg;
    assign wr_data_out   = wr_data_reg;
endmodule : aad_datapath
`default_nettype wire

// >>> logic/aad_pkg.sv
`default_nettype none
package aad_pkg;
    // ------------------------------------------------------------
    // Widths and sizes
    // ------------------------------------------------------------
    localparam int DATA_W     = 8;
    localparam int INSTR_W    = 14;
    localparam int PC_W       = 13;
    localparam int FILE_AW    = 7;
    localparam int FILE_DEPTH = 128;
    localparam int TGT_W      = 11;
    // ------------------------------------------------------------
    // Instruction fields
    // ------------------------------------------------------------
    localparam int CLASS_HI = 13;
    localparam int CLASS_LO = 12;
    localparam int OP_HI    = 11;
    localparam int OP_LO    = 8;
    localparam int DEST_BIT = 7;
    localparam logic [1:0] CLS_FILE   = 2'h0;
    localparam logic [1:0] CLS_BRANCH = 2'h2;
    localparam logic [1:0] CLS_LIT    = 2'h3;
    // ------------------------------------------------------------
    // Mapped special registers and status bits
    // ------------------------------------------------------------
    localparam logic [6:0] ADDR_INDIRECT = 7'h00;
    localparam logic [6:0] ADDR_PC_LOW   = 7'h02;
    localparam logic [6:0] ADDR_STATUS   = 7'h03;
    localparam logic [6:0] ADDR_POINTER  = 7'h04;
    localparam int STAT_C  = 0;
    localparam int STAT_DC = 1;
    localparam int STAT_Z  = 2;
    // ------------------------------------------------------------
    // Reset values and counts
    // ------------------------------------------------------------
    localparam logic [7:0]  W_RST      = 8'h00;
    localparam logic [7:0]  STATUS_RST = 8'h00;
    localparam logic [7:0]  PTR_RST    = 8'h00;
    localparam logic [12:0] PC_RST     = 13'h0000;
    localparam logic [13:0] INSTR_NOP  = 14'h0000;
    localparam logic [12:0] PC_STEP    = 13'h0001;
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_NOP  = 4'h0, OP_MOVWF = 4'h1, OP_CLR  = 4'h2, OP_SUB  = 4'h3,
        OP_DEC  = 4'h4, OP_IOR   = 4'h5, OP_AND  = 4'h6, OP_XOR  = 4'h7,
        OP_ADD  = 4'h8, OP_MOV   = 4'h9, OP_COM  = 4'hA, OP_INC  = 4'hB,
        OP_RRF  = 4'hC, OP_RLF   = 4'hD, OP_SWAP = 4'hE, OP_RSVD = 4'hF
    } aad_op_t;
    typedef enum logic [3:0] {
        PH_DECODE       = 4'b0001,
        PH_OPERAND_READ = 4'b0010,
        PH_EXECUTE      = 4'b0100,
        PH_RESULT_WRITE = 4'b1000
    } aad_phase_t;
    typedef struct packed {
        aad_op_t     op;
        logic        uses_file;
        logic        operand_w;
        logic        dest_file;
        logic        dest_w;
        logic        is_branch;
        logic [2:0]  flag_mask;
        logic [6:0]  faddr;
        logic [7:0]  literal;
        logic [10:0] target;
    } aad_decode_t;
    typedef struct packed {
        logic [7:0] result;
        logic       carry;
        logic       nibble_borrow_flag;
        logic       zero;
    } aad_alu_t;
endpackage : aad_pkg
`default_nettype wire

// >>> logic/aad_phase_gen.sv
`timescale 1ns/1ps
`default_nettype none
module aad_phase_gen (
    // Clock, reset and enable
    input  wire logic          clock_in,
    input  wire logic          rstn_in,
    input  wire logic          clk_en_in,
    // Current phase
    output var aad_pkg::aad_phase_t phase_out
);
    aad_pkg::aad_phase_t phase_reg;
    aad_pkg::aad_phase_t phase_next;

    // Rotate through the four phases of an instruction cycle
    always_comb begin
        case (phase_reg)
            aad_pkg::PH_DECODE:       phase_next = aad_pkg::PH_OPERAND_READ;
            aad_pkg::PH_OPERAND_READ: phase_next = aad_pkg::PH_EXECUTE;
            aad_pkg::PH_EXECUTE:      phase_next = aad_pkg::PH_RESULT_WRITE;
            aad_pkg::PH_RESULT_WRITE: phase_next = aad_pkg::PH_DECODE;
            default:                  phase_next = aad_pkg::PH_DECODE;
        endcase
    end

    // Phase register
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            phase_reg <= aad_pkg::PH_DECODE;
        end else if (clk_en_in) begin
            phase_reg <= phase_next;
        end
    end

    assign phase_out = phase_reg;
endmodule : aad_phase_gen
`default_nettype wire

// >>> logic/aad_file_mem.sv
`timescale 1ns/1ps
`default_nettype none
module aad_file_mem #(
    parameter int ADDR_W = 7,
    parameter int DATA_W = 8,
    parameter int DEPTH  = 128
) (
    // Clock, reset and enable
    input  wire logic              clock_in,
    input  wire logic              rstn_in,
    input  wire logic              clk_en_in,
    // Read port, data registered
    input  wire logic              rd_en_in,
    input  wire logic [ADDR_W-1:0] rd_addr_in,
    output logic      [DATA_W-1:0] rd_data_out,
    // Write port
    input  wire logic              wr_en_in,
    input  wire logic [ADDR_W-1:0] wr_addr_in,
    input  wire logic [DATA_W-1:0] wr_data_in
);
    logic [DATA_W-1:0] mem_reg [DEPTH];
    logic [DATA_W-1:0] rd_data_reg;
    logic [DATA_W-1:0] rd_data_next;

    // Read mux; addresses past the depth read as zero
    always_comb begin
        rd_data_next = rd_data_reg;
        if (rd_en_in) begin
            rd_data_next = (int'(rd_addr_in) < DEPTH) ? mem_reg[rd_addr_in] : '0;
        end
    end

    // Read data register
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            rd_data_reg <= '0;
        end else if (clk_en_in) begin
            rd_data_reg <= rd_data_next;
        end
    end

    // Storage array, no reset
    always_ff @(posedge clock_in) begin
        if (clk_en_in && wr_en_in && (int'(wr_addr_in) < DEPTH)) begin
            mem_reg[wr_addr_in] <= wr_data_in;
        end
    end

    assign rd_data_out = rd_data_reg;
endmodule : aad_file_mem
`default_nettype wire

// >>> sim/aad_datapath_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module aad_datapath_asserts (
    // Clock and controls
    input wire logic        clock_in,
    input wire logic        rstn_in,
    input wire logic        clk_en_in,
    input wire logic        master_clear_n_in,
    // Observed outputs
    input wire logic [12:0] prog_addr_out,
    input wire logic [7:0]  accum_out,
    input wire logic [7:0]  status_out,
    input var aad_pkg::aad_phase_t phase_out,
    input wire logic        cycle_out,
    input wire logic        wr_strobe_out
);
    logic [3:0] hold_reg;
    // Covers the synchroniser delay after either reset source
    always_ff @(posedge clock_in) hold_reg <= {hold_reg[2:0], !(rstn_in && master_clear_n_in)};
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rstn_in || !master_clear_n_in || (|hold_reg));
    property p_ph12; clk_en_in && phase_out == aad_pkg::PH_DECODE |=> phase_out == aad_pkg::PH_OPERAND_READ; endproperty
    a_ph12: assert property (p_ph12) else $error("read phase late");
    property p_ph41; clk_en_in && phase_out == aad_pkg::PH_RESULT_WRITE |=> phase_out == aad_pkg::PH_DECODE; endproperty
    a_ph41: assert property (p_ph41) else $error("cycle not closed");
    property p_cyc; cycle_out == phase_out[0]; endproperty
    a_cyc: assert property (p_cyc) else $error("cycle marker wrong");
    property p_pc; clk_en_in && phase_out != aad_pkg::PH_DECODE |=> $stable(prog_addr_out); endproperty
    a_pc: assert property (p_pc) else $error("fetch address moved");
    property p_gap; $changed(prog_addr_out) |=> $stable(prog_addr_out) [*3]; endproperty
    a_gap: assert property (p_gap) else $error("fetches too close");
    property p_res; clk_en_in && phase_out != aad_pkg::PH_RESULT_WRITE |=> $stable(accum_out) && $stable(status_out); endproperty
    a_res: assert property (p_res) else $error("result outside write phase");
    property p_wph; wr_strobe_out |-> phase_out == aad_pkg::PH_DECODE; endproperty
    a_wph: assert property (p_wph) else $error("write strobe phase");
    property p_wone; clk_en_in && wr_strobe_out |=> !wr_strobe_out; endproperty
    a_wone: assert property (p_wone) else $error("write strobe too long");
endmodule : aad_datapath_asserts
bind aad_datapath aad_datapath_asserts u_chk (.clock_in, .rstn_in, .clk_en_in, .master_clear_n_in,
    .prog_addr_out, .accum_out, .status_out, .phase_out, .cycle_out, .wr_strobe_out);
`default_nettype wire

// >>> sim/aad_prog_rom.sv
`timescale 1ns/1ps
`default_nettype none
module aad_prog_rom (
    // Fetch address and word
    input wire logic [12:0] addr_in,
    output logic     [13:0] word_out
);
    logic [13:0] mem [8];
    // Word for the address, no-op beyond the loaded range
    assign word_out = (addr_in < 13'h0008) ? mem[addr_in[2:0]] : aad_pkg::INSTR_NOP;
endmodule : aad_prog_rom
`default_nettype wire

// >>> sim/aad_datapath_tb.sv
`timescale 1ns/1ps
`default_nettype none
module aad_datapath_tb;
    // ----------------------------------------------------------
    // Bench signals
    // ----------------------------------------------------------
    localparam logic [13:0] NOP = 14'h0000;
    logic clock_in = 1'b0;
    logic rstn_in = 1'b0;
    logic master_clear_input_n = 1'b0;
    logic clk_en = 1'b1;
    logic [12:0] paddr;
    logic [13:0] pword;
    logic [7:0] acc, st, wdat;
    logic [6:0] wadr;
    logic wstb;
    int n_mismatch = 0;
    int tests_run = 0;
    int n_wr;
    // Clock, 10 ns period
    always #5 clock_in = ~clock_in;
    aad_datapath dut (.clock_in, .rstn_in, .clk_en_in(clk_en), .master_clear_n_in(master_clear_input_n),
        .prog_word_in(pword), .prog_addr_out(paddr), .accum_out(acc), .status_out(st),
        .phase_out(), .cycle_out(), .wr_strobe_out(wstb), .wr_addr_out(wadr), .wr_data_out(wdat));
    aad_prog_rom rom (.addr_in(paddr), .word_out(pword));
    // ----------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check
    // Load a program, clear the core through the pin, count file writes;
    // with stall set, every third clock is frozen once the core is running
    task automatic run(input logic [13:0] p [8], input bit stall = 1'b0);
        rom.mem = p;
        @(negedge clock_in) master_clear_input_n = 1'b0;
        repeat (4) @(negedge clock_in);
        master_clear_input_n = 1'b1;
        n_wr = 0;
        for (int i = 0; i < 60; i++) begin
            @(negedge clock_in);
            n_wr += int'(wstb);
            clk_en = !(stall && i >= 8 && i % 3 == 0); // Last pass leaves it high
        end
    endtask : run
    task automatic report_and_stop;
        $display("comparisons %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : report_and_stop
    // ----------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------
    task automatic t_add;
        run('{14'h390F, 14'h3801, 14'h2002, NOP, NOP, NOP, NOP, NOP});
        check("accum", 8'h10, acc);
        check("status", 8'h02, st);
    endtask : t_add
    task automatic t_nibble;
        run('{14'h3901, 14'h3310, 14'h2002, NOP, NOP, NOP, NOP, NOP});
        check("accum", 8'h0F, acc);
        check("status", 8'h01, st);
    endtask : t_nibble
    task automatic t_borrow;
        run('{14'h3901, 14'h3301, 14'h3901, 14'h3300, 14'h2004, NOP, NOP, NOP});
        check("accum", 8'hFF, acc);
        check("status", 8'h00, st);
    endtask : t_borrow
    task automatic t_file;
        run('{14'h390F, 14'h01A0, 14'h0820, 14'h2003, NOP, NOP, NOP, NOP});
        check("accum", 8'h1E, acc);
        check("status", 8'h02, st);
        check("wr_addr", 8'h20, {1'b0, wadr});
        check("wr_data", 8'h0F, wdat);
        check("writes", 8'h01, 8'(n_wr));
    endtask : t_file
    task automatic t_branch;
        run('{14'h39AA, 14'h2003, 14'h3955, 14'h2003, NOP, NOP, NOP, NOP}, 1'b1);
        check("accum", 8'hAA, acc);
        check("status", 8'h00, st);
    endtask : t_branch
    // Main sequence
    initial begin
        repeat (16) @(negedge clock_in);
        rstn_in = 1'b1;
        t_add;
        t_nibble;
        t_borrow;
        t_file;
        t_branch;
        report_and_stop;
    end
endmodule : aad_datapath_tb
`default_nettype wire
